// file: hdl/rtctk_pkg.sv
// constants for the real-time clock timekeeping and alarm core
package rtctk_pkg;
    localparam logic [15:0] DEF_IO_BASE = 16'h0070;
    localparam logic [6:0] IDX_SEC = 7'h00;
    localparam logic [6:0] IDX_CRA = 7'h0a;
    localparam logic [6:0] IDX_CRB = 7'h0b;
    localparam logic [6:0] IDX_CRC = 7'h0c;
    localparam logic [6:0] IDX_CRD = 7'h0d;
    localparam logic [6:0] IDX_CEN = 7'h48;
    localparam logic [6:0] IDX_DALM = 7'h49;
    localparam logic [6:0] IDX_MALM = 7'h4a;
    // pointers in bank 2: bit 7 bank, bits 6-0 index
    localparam logic [6:0] IDX_PTR0 = 7'h48;
    localparam logic [7:0] PTR_CEN_RST = 8'hc8;
    localparam logic [7:0] PTR_DALM_RST = 8'hc9;
    localparam logic [7:0] PTR_MALM_RST = 8'hca;
    localparam logic [6:0] CRA_RST = 7'h60;
    localparam logic [7:0] CRB_RST = 8'h02;
    localparam logic [7:0] CEN_RST = 8'h14;
    localparam logic [7:0] CRD_VAL = 8'h80;
    localparam int B_SET = 7;
    localparam int B_DM = 2;
    localparam int B_H24 = 1;
    localparam int B_DSE = 0;
    localparam logic [2:0] DV_BANK0 = 3'b010;
    localparam logic [2:0] DV_BANK1 = 3'b011;
    localparam logic [2:0] DV_BANK2 = 3'b100;
    localparam int DIV_W = 15;
    localparam int OSC_HZ = 32768;
    localparam int UIP_LEAD_US = 244;
    localparam int UIP_TICKS = (UIP_LEAD_US * OSC_HZ + 999999) / 1000000;
    localparam logic [DIV_W-1:0] UIP_START = 15'h4000;
    localparam logic [DIV_W-1:0] UPD_POINT = UIP_START + 15'(UIP_TICKS);
endpackage

// file: hdl/rtctk_core.sv
// timekeeping, periodic, update and alarm core behind an index/data port
// How it works
// [RULE_01] divide the 32768 Hz tick by 2^15 for the once-per-second update
// [RULE_02] control A bits 6-4 steer divider and bank, bits 3-0 pick tap
// [RULE_03] reset codes clear the divider; first update 500 ms after start
// [RULE_04] first periodic flag comes half a period after the chain starts
// [RULE_05] control B bit 2 picks BCD or binary, bit 1 picks 12/24 hour
// [RULE_06] software rewrites all time registers after a format change
// [RULE_07] summer time: 1:59:59 to 3:00 in April, back to 1:00 in October
// [RULE_08] month lengths automatic, February has 29 days in leap years
// [RULE_09] seconds through century advance once each second
// [RULE_10] host must not touch time registers during an update
// [RULE_11] raising the set bit snapshots time into the user copy
// [RULE_12] dropping the set bit loads modified user copy fields
// [RULE_13] update-ended event right after update, 999 ms to the next
// [RULE_14] update-in-progress rises 244 us before each update; the code keeps it low before updates while the set bit is high
// [RULE_15] periodic event lands half a period plus 244 us before update
// [RULE_16] after each update compare time against the alarm registers
// [RULE_17] full match sets alarm flag; request only with alarm enable
// [RULE_18] alarm field with bits 7,6 both set matches any value
// [RULE_19] seconds, minutes, hours alarms at 01h, 03h, 05h in every bank
// [RULE_20] date and month alarms at bank 1 49h/4Ah, movable by pointers
// [RULE_21] century at bank 1 48h by default, movable by a pointer
// [RULE_22] index port at 70h, data port at 71h, base set by configuration
// [RULE_23] divider codes: off, normal bank 0/1/2, test, held in reset; the code runs the chain as bank 0 for off and test
// [RULE_24] one active-low request for enabled periodic, alarm, update
// [RULE_25] reading control C clears all its flags at once
// [RULE_26] update-ended flag set at the end of every update
`timescale 1ns/10ps
`default_nettype none
module rtctk_core
(
    input  wire logic        CLOCK_I,
    input  wire logic        RSTN_I,
    input  wire logic        OSC_TICK_I,
    input  wire logic [15:0] IO_BASE_I,
    input  wire logic [15:0] IO_ADDR_I,
    input  wire logic        IO_RD_I,
    input  wire logic        IO_WR_I,
    input  wire logic [7:0]  IO_WDATA_I,
    output logic      [7:0]  IO_RDATA_O,
    output logic             IRQ_N_O
);
    import rtctk_pkg::*;

    typedef struct packed {
        logic [6:0]      idx;
        logic [6:0]      divider_rate_control;
        logic [7:0]      format_interrupt_control;
        logic [2:0]      flg;
        logic [7:0][7:0] tm;
        logic [7:0][7:0] uc;
        logic [7:0]      dirty;
        logic [4:0][7:0] alm;
        logic [2:0][7:0] ptr;
        logic [14:0]     div;
        logic            update_pending_flag;
        logic            chk;
        logic            fb_done;
        logic            irq_n;
        logic [7:0]      rdata;
    } rtctk_state_t;

    rtctk_state_t s_q;
    rtctk_state_t s_d;

    function automatic logic [7:0] bin2bcd(input logic [7:0] v);
        logic [7:0] t;
        t = v / 8'd10;
        return {t[3:0], 4'(v - 8'(t * 8'd10))};
    endfunction

    function automatic logic [7:0] bcd2bin(input logic [7:0] v);
        return 8'({4'h0, v[7:4]} * 8'd10) + {4'h0, v[3:0]};
    endfunction

    // internal counters are binary, 24 hour; host view converted here
    function automatic logic [7:0] to_host(input logic [7:0] v,
                                           input logic hr, input logic bcd,
                                           input logic h24);
        logic [7:0] h;
        logic       pm;
        h = v;
        pm = 1'b0;
        if (hr && !h24)
        begin
            pm = v >= 8'd12;
            h = pm ? v - 8'd12 : v;
            if (h == 8'd0)
                h = 8'd12;
        end
        h = bcd ? bin2bcd(h) : h;
        return {pm | h[7], h[6:0]};
    endfunction

    function automatic logic [7:0] from_host(input logic [7:0] d,
                                             input logic hr, input logic bcd,
                                             input logic h24);
        logic [7:0] h;
        h = (hr && !h24) ? {1'b0, d[6:0]} : d;
        h = bcd ? bcd2bin(h) : h;
        if (hr && !h24)
        begin
            if (h == 8'd12)
                h = 8'd0;
            if (d[7])
                h = h + 8'd12;
        end
        return h;
    endfunction

    function automatic logic [7:0] days_in(input logic [7:0] mon,
                                           input logic [7:0] yr,
                                           input logic [7:0] cen);
        logic leap;
        leap = (yr[1:0] == 2'b00) && (yr != 8'd0 || cen[1:0] == 2'b00);
        case (mon)
            8'd2:  return leap ? 8'd29 : 8'd28;
            8'd4, 8'd6, 8'd9, 8'd11: return 8'd30;
            default: return 8'd31;
        endcase
    endfunction

    // tap bit whose rise marks a periodic event; codes 1,2 alias 8,9
    function automatic logic [3:0] tap_bit(input logic [3:0] rs);
        logic [3:0] r;
        r = (rs == 4'd1 || rs == 4'd2) ? rs + 4'd7 : rs;
        return r - 4'd2;
    endfunction

    logic [2:0]  dv;
    logic [1:0]  bank;
    logic        run;
    logic        bcd;
    logic        h24;
    logic [14:0] nxt;
    logic        pev;
    logic        aev;
    logic        uev;
    logic        rd_c;
    logic        hit_idx;
    logic        hit_dat;
    logic        is_tm;
    logic [2:0]  f;
    logic        is_alm;
    logic [2:0]  ai;
    logic        is_ptr;
    logic [1:0]  pi;
    logic [7:0]  rv;
    logic [7:0]  hv;
    logic [7:0]  t [8];
    logic        am;
    logic [2:0]  fi;

    always_comb
    begin
        s_d = s_q;
        dv = s_q.divider_rate_control[6:4];
        bank = (dv == DV_BANK1) ? 2'd1 : (dv == DV_BANK2) ? 2'd2 : 2'd0; // [RULE_23]
        run = dv[2:1] != 2'b11;                                           // [RULE_23]
        bcd = !s_q.format_interrupt_control[B_DM];                                             // [RULE_05]
        h24 = s_q.format_interrupt_control[B_H24];                                             // [RULE_05]
        nxt = s_q.div + 15'd1;
        pev = 1'b0;
        aev = 1'b0;
        uev = 1'b0;
        rd_c = 1'b0;
        rv = 8'h00;
        hv = 8'h00;
        am = 1'b1;
        fi = 3'd0;
        for (int i = 0; i < 8; i++)
            t[i] = s_q.tm[i];

        // divider chain, advanced by the slow oscillator tick
        if (!run)
            s_d.div = '0;                                                 // [RULE_03]
        else if (OSC_TICK_I)
        begin
            s_d.div = nxt;                                                // [RULE_01]
            pev = (s_q.divider_rate_control[3:0] != 4'd0) && nxt[tap_bit(s_q.divider_rate_control[3:0])]
                  && !s_q.div[tap_bit(s_q.divider_rate_control[3:0])];         // [RULE_02] [RULE_04] [RULE_15]
            uev = nxt == UPD_POINT;                                       // [RULE_03]
        end
        // status window sits just ahead of the update point
        s_d.update_pending_flag = run && !s_d.format_interrupt_control[B_SET] && s_d.div >= UIP_START
                  && s_d.div < UPD_POINT;                                 // [RULE_14]

        // once-per-second advance; internal counters keep running under set
        if (uev)
        begin
            if (s_q.format_interrupt_control[B_DSE] && t[5] == 8'd4 && t[3] == 8'd1
                && t[4] <= 8'd7 && t[2] == 8'd1 && t[1] == 8'd59
                && t[0] == 8'd59)
            begin
                t[2] = 8'd3;                                              // [RULE_07]
                t[1] = 8'd0;
                t[0] = 8'd0;
            end
            else if (s_q.format_interrupt_control[B_DSE] && t[5] == 8'd10 && t[3] == 8'd1
                     && t[4] > 8'd24 && t[2] == 8'd1 && t[1] == 8'd59
                     && t[0] == 8'd59 && !s_q.fb_done)
            begin
                t[1] = 8'd0;                                              // [RULE_07]
                t[0] = 8'd0;
                s_d.fb_done = 1'b1;
            end
            else if (t[0] != 8'd59)
                t[0] = t[0] + 8'd1;                                       // [RULE_09]
            else
            begin
                t[0] = 8'd0;
                if (t[1] != 8'd59)
                    t[1] = t[1] + 8'd1;
                else
                begin
                    t[1] = 8'd0;
                    if (t[2] != 8'd23)
                        t[2] = t[2] + 8'd1;
                    else
                    begin
                        t[2] = 8'd0;
                        s_d.fb_done = 1'b0;
                        t[3] = (t[3] == 8'd7) ? 8'd1 : t[3] + 8'd1;
                        if (t[4] < days_in(t[5], t[6], t[7]))     // [RULE_08]
                            t[4] = t[4] + 8'd1;
                        else
                        begin
                            t[4] = 8'd1;
                            if (t[5] != 8'd12)
                                t[5] = t[5] + 8'd1;
                            else
                            begin
                                t[5] = 8'd1;
                                if (t[6] != 8'd99)
                                    t[6] = t[6] + 8'd1;
                                else
                                begin
                                    t[6] = 8'd0;
                                    t[7] = (t[7] == 8'd99) ? 8'd0
                                                           : t[7] + 8'd1;
                                end
                            end
                        end
                    end
                end
            end
            for (int i = 0; i < 8; i++)
                s_d.tm[i] = t[i];
        end
        s_d.chk = uev;

        // alarm compare one cycle after the update has settled
        if (s_q.chk)
        begin
            for (int i = 0; i < 5; i++)
            begin
                fi = (i < 3) ? 3'(i) : 3'(i + 1);
                if (s_q.alm[i][7:6] != 2'b11)                             // [RULE_18]
                    am = am && (from_host(s_q.alm[i], i == 2, bcd, h24)
                                == s_q.tm[fi]);                           // [RULE_16]
            end
            aev = am;                                                     // [RULE_17]
        end

        // data port decode: common area, relocatable and pointer registers
        hit_idx = IO_ADDR_I == IO_BASE_I;                                 // [RULE_22]
        hit_dat = IO_ADDR_I == 16'(IO_BASE_I + 16'd1);                    // [RULE_22]
        is_tm = 1'b0;
        f = 3'd0;
        is_alm = 1'b0;
        ai = 3'd0;
        is_ptr = 1'b0;
        pi = 2'd0;
        case (s_q.idx)
            7'h00: begin is_tm = 1'b1; f = 3'd0; end
            7'h02: begin is_tm = 1'b1; f = 3'd1; end
            7'h04: begin is_tm = 1'b1; f = 3'd2; end
            7'h06: begin is_tm = 1'b1; f = 3'd3; end
            7'h07: begin is_tm = 1'b1; f = 3'd4; end
            7'h08: begin is_tm = 1'b1; f = 3'd5; end
            7'h09: begin is_tm = 1'b1; f = 3'd6; end
            7'h01: begin is_alm = 1'b1; ai = 3'd0; end                   // [RULE_19]
            7'h03: begin is_alm = 1'b1; ai = 3'd1; end                   // [RULE_19]
            7'h05: begin is_alm = 1'b1; ai = 3'd2; end                   // [RULE_19]
            default:
            begin
                if (bank == 2'd2 && s_q.idx >= IDX_PTR0
                    && s_q.idx <= IDX_PTR0 + 7'd2)
                begin
                    is_ptr = 1'b1;
                    pi = 2'(s_q.idx - IDX_PTR0);
                end
                else if (bank != 2'd2)
                begin
                    if (s_q.ptr[0] == {bank[0], s_q.idx})                // [RULE_21]
                    begin
                        is_tm = 1'b1;
                        f = 3'd7;
                    end
                    else if (s_q.ptr[1] == {bank[0], s_q.idx})           // [RULE_20]
                    begin
                        is_alm = 1'b1;
                        ai = 3'd3;
                    end
                    else if (s_q.ptr[2] == {bank[0], s_q.idx})           // [RULE_20]
                    begin
                        is_alm = 1'b1;
                        ai = 3'd4;
                    end
                end
            end
        endcase

        if (is_tm)
            rv = to_host(s_q.format_interrupt_control[B_SET] ? s_q.uc[f] : s_q.tm[f],
                         f == 3'd2, bcd, h24);                            // [RULE_05]
        else if (is_alm)
            rv = s_q.alm[ai];
        else if (is_ptr)
            rv = s_q.ptr[pi];
        else if (s_q.idx == IDX_CRA)
            rv = {s_q.update_pending_flag, s_q.divider_rate_control};                                      // [RULE_14]
        else if (s_q.idx == IDX_CRB)
            rv = s_q.format_interrupt_control;
        else if (s_q.idx == IDX_CRC)
            rv = {|(s_q.flg & s_q.format_interrupt_control[6:4]), s_q.flg, 4'h0};
        else if (s_q.idx == IDX_CRD)
            rv = CRD_VAL;

        if (IO_RD_I && hit_idx)
            s_d.rdata = {1'b0, s_q.idx};
        else if (IO_RD_I && hit_dat)
        begin
            s_d.rdata = rv;
            rd_c = s_q.idx == IDX_CRC;                                    // [RULE_25]
        end

        if (IO_WR_I && hit_idx)
            s_d.idx = IO_WDATA_I[6:0];
        else if (IO_WR_I && hit_dat)
        begin
            hv = from_host(IO_WDATA_I, f == 3'd2, bcd, h24);
            if (is_tm && s_q.format_interrupt_control[B_SET])
            begin
                s_d.uc[f] = hv;
                s_d.dirty[f] = 1'b1;
            end
            else if (is_tm)
                s_d.tm[f] = hv;
            else if (is_alm)
                s_d.alm[ai] = IO_WDATA_I;
            else if (is_ptr)
                s_d.ptr[pi] = IO_WDATA_I;
            else if (s_q.idx == IDX_CRA)
                s_d.divider_rate_control = IO_WDATA_I[6:0];                                // [RULE_02]
            else if (s_q.idx == IDX_CRB)
            begin
                s_d.format_interrupt_control = IO_WDATA_I;
                if (IO_WDATA_I[B_SET] && !s_q.format_interrupt_control[B_SET])
                begin
                    s_d.uc = s_d.tm;                                      // [RULE_11]
                    s_d.dirty = 8'h00;
                end
                else if (!IO_WDATA_I[B_SET] && s_q.format_interrupt_control[B_SET])
                    for (int i = 0; i < 8; i++)
                        if (s_q.dirty[i])
                            s_d.tm[i] = s_q.uc[i];                        // [RULE_12]
            end
        end

        // a new event in the clearing read cycle survives
        s_d.flg = (rd_c ? 3'b000 : s_q.flg) | {pev, aev, uev};            // [RULE_13] [RULE_26]
        s_d.irq_n = !(|(s_d.flg & s_d.format_interrupt_control[6:4]));                         // [RULE_24] [RULE_17]
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            s_q <= '0;
            s_q.divider_rate_control <= CRA_RST;
            s_q.format_interrupt_control <= CRB_RST;
            s_q.tm[3] <= 8'h01;
            s_q.tm[4] <= 8'h01;
            s_q.tm[5] <= 8'h01;
            s_q.tm[7] <= CEN_RST;
            s_q.ptr[0] <= PTR_CEN_RST;
            s_q.ptr[1] <= PTR_DALM_RST;
            s_q.ptr[2] <= PTR_MALM_RST;
            s_q.irq_n <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign IO_RDATA_O = s_q.rdata;
    assign IRQ_N_O = s_q.irq_n;
endmodule
`default_nettype wire

// file: testbench/rtctk_chk.sv
// port-level assertions for the timekeeping core
`timescale 1ns/10ps
`default_nettype none
module rtctk_chk
    import rtctk_pkg::*;
(
    input wire logic        CLOCK_I,
    input wire logic        RSTN_I,
    input wire logic        OSC_TICK_I,
    input wire logic [15:0] IO_BASE_I,
    input wire logic [15:0] IO_ADDR_I,
    input wire logic        IO_RD_I,
    input wire logic        IO_WR_I,
    input wire logic [7:0]  IO_WDATA_I,
    input wire logic [7:0]  IO_RDATA_O,
    input wire logic        IRQ_N_O
);
    logic [6:0] idx_q;
    logic [6:0] a_q;
    logic [7:0] b_q;
    logic       ix_rd;
    logic       dt_rd;
    logic       dt_wr;
    logic       ev;
    assign ix_rd = IO_RD_I && IO_ADDR_I == IO_BASE_I;
    assign dt_rd = IO_RD_I && IO_ADDR_I == IO_BASE_I + 16'h0001;
    assign dt_wr = IO_WR_I && IO_ADDR_I == IO_BASE_I + 16'h0001;
    assign ev = OSC_TICK_I || dt_wr;
    // shadow of index and control registers as the host wrote them
    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            idx_q <= 7'h00;
            a_q   <= CRA_RST;
            b_q   <= CRB_RST;
        end
        else
        begin
            if (IO_WR_I && IO_ADDR_I == IO_BASE_I)
                idx_q <= IO_WDATA_I[6:0];
            if (dt_wr && idx_q == IDX_CRA)
                a_q <= IO_WDATA_I[6:0];
            if (dt_wr && idx_q == IDX_CRB)
                b_q <= IO_WDATA_I;
        end
    end
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RSTN_I);
    property p_rdata_hold;
        !$past(IO_RD_I) |-> $stable(IO_RDATA_O);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without a read");
    property p_index_rd;
        ix_rd |=> IO_RDATA_O == {1'b0, idx_q};
    endproperty
    a_index_rd: assert property (p_index_rd)
        else $error("index port read back wrong");
    property p_a_rd;
        dt_rd && idx_q == IDX_CRA |=> IO_RDATA_O[6:0] == a_q
            && !(a_q[6:5] == 2'b11 && IO_RDATA_O[7]);
    endproperty
    a_a_rd: assert property (p_a_rd)
        else $error("divider control read back wrong");
    property p_uip_set;
        dt_rd && idx_q == IDX_CRA && b_q[B_SET] |=> !IO_RDATA_O[7];
    endproperty
    a_uip_set: assert property (p_uip_set)
        else $error("update pending seen while set bit high");
    property p_b_rd;
        dt_rd && idx_q == IDX_CRB |=> IO_RDATA_O == b_q;
    endproperty
    a_b_rd: assert property (p_b_rd)
        else $error("format control read back wrong");
    property p_c_low;
        dt_rd && idx_q == IDX_CRC |=> IO_RDATA_O[3:0] == 4'h0;
    endproperty
    a_c_low: assert property (p_c_low)
        else $error("flag register low bits not zero");
    property p_c_clear;
        dt_rd && idx_q == IDX_CRC && !OSC_TICK_I && !$past(OSC_TICK_I)
            && !$past(OSC_TICK_I, 2) |=> IRQ_N_O;
    endproperty
    a_c_clear: assert property (p_c_clear)
        else $error("request stayed after flag read");
    property p_irq_en;
        $fell(IRQ_N_O) |-> b_q[6:4] != 3'b000;
    endproperty
    a_irq_en: assert property (p_irq_en)
        else $error("request without any enable");
    property p_irq_cause;
        $fell(IRQ_N_O) |-> $past(ev) || $past(ev, 2) || $past(ev, 3);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("request fell with no event");
    c_uf: cover property (dt_rd && idx_q == IDX_CRC ##1 IO_RDATA_O[4]);
    c_irq: cover property ($fell(IRQ_N_O));
    c_uip: cover property (dt_rd && idx_q == IDX_CRA ##1 IO_RDATA_O[7]);
endmodule
`default_nettype wire

// file: testbench/rtctk_host.sv
// host model driving the index/data port pair
`timescale 1ns/10ps
`default_nettype none
module rtctk_host
(
    input  wire logic        clock_i,
    input  wire logic [15:0] base_i,
    input  wire logic [7:0]  rdata_i,
    output logic      [15:0] addr_o,
    output logic             rd_o,
    output logic             wr_o,
    output logic      [7:0]  wdata_o
);
    initial
    begin
        addr_o = 16'h0000;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 8'h00;
    end
    // one strobe cycle; idle lines flip so stale values cannot match
    task automatic io_cyc(input logic [15:0] a, input logic rd,
                          input logic [7:0] d, output logic [7:0] q);
        @(negedge clock_i);
        addr_o = a;
        rd_o = rd;
        wr_o = !rd;
        wdata_o = d;
        @(negedge clock_i);
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
        q = rdata_i;
    endtask
    task automatic reg_wr(input logic [6:0] idx, input logic [7:0] d);
        logic [7:0] q;
        io_cyc(base_i, 1'b0, {1'b0, idx}, q);
        io_cyc(base_i + 16'h0001, 1'b0, d, q);
    endtask
    task automatic reg_rd(input logic [6:0] idx, output logic [7:0] q);
        io_cyc(base_i, 1'b0, {1'b0, idx}, q);
        io_cyc(base_i + 16'h0001, 1'b1, 8'h00, q);
    endtask
endmodule
`default_nettype wire

// file: testbench/rtctk_core_bench.sv
// self-checking bench for the timekeeping core
`timescale 1ns/10ps
`default_nettype none
module rtctk_core_bench;
    import rtctk_pkg::*;
    logic clock = 1'b0, rstn = 1'b0, osc_tick = 1'b0, io_rd, io_wr, irq_n;
    logic [15:0] io_base = DEF_IO_BASE;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata, io_rdata, q;
    int failures = 0, comparisons = 0;
    logic [6:0] s_idx [10] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04,
                               7'h05, 7'h06, 7'h07, 7'h08, 7'h09};
    logic [7:0] s_val [10] = '{8'h59, 8'h00, 8'h59, 8'hc0, 8'h23,
                               8'hc0, 8'h03, 8'h28, 8'h02, 8'h23};
    logic [7:0] t_val [10] = '{8'h00, 8'h00, 8'h00, 8'hc0, 8'h00,
                               8'hc0, 8'h04, 8'h01, 8'h03, 8'h23};
    logic [7:0] p_val [3] = '{PTR_CEN_RST, PTR_DALM_RST, PTR_MALM_RST};
    logic [7:0] d_val [5] = '{8'h59, 8'h59, 8'h01, 8'h01, 8'h04};
    always #10 clock = ~clock;
    rtctk_core rtctk_core_inst (.CLOCK_I(clock), .RSTN_I(rstn),
        .OSC_TICK_I(osc_tick), .IO_BASE_I(io_base), .IO_ADDR_I(io_addr),
        .IO_RD_I(io_rd), .IO_WR_I(io_wr), .IO_WDATA_I(io_wdata),
        .IO_RDATA_O(io_rdata), .IRQ_N_O(irq_n));
    rtctk_host rtctk_host_inst (.clock_i(clock), .base_i(io_base),
        .rdata_i(io_rdata), .addr_o(io_addr), .rd_o(io_rd), .wr_o(io_wr),
        .wdata_o(io_wdata));
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd_chk(input logic [6:0] idx, input logic [7:0] e,
                          input string nm);
        logic [7:0] r;
        rtctk_host_inst.reg_rd(idx, r);
        chk(nm, e, r);
    endtask
    // ticks stop before any host access, so no access meets an update
    task automatic tick(input int n);
        @(negedge clock);
        osc_tick = 1'b1;
        repeat (n) @(negedge clock);
        osc_tick = 1'b0;
        repeat (3) @(negedge clock);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (100000) @(posedge clock);
        failures++;
        close_out();
    end
    initial
    begin
        repeat (2) @(posedge clock);
        @(negedge clock);
        rstn = 1'b1;
        rd_chk(IDX_CRA, {1'b0, CRA_RST}, "ctrl a");
        rd_chk(IDX_CRB, CRB_RST, "ctrl b");
        rd_chk(IDX_CRC, 8'h00, "flags");
        rd_chk(IDX_CRD, CRD_VAL, "power");
        rd_chk(7'h20, 8'h00, "unmapped");
        rtctk_host_inst.io_cyc(io_base, 1'b0, 8'h8b, q);
        rtctk_host_inst.io_cyc(io_base, 1'b1, 8'h00, q);
        chk("index", 8'h0b, q);
        rtctk_host_inst.reg_wr(IDX_CRC, 8'hff);
        rd_chk(IDX_CRC, 8'h00, "flags ro");
        rtctk_host_inst.reg_wr(IDX_CRA, {1'b0, DV_BANK2, 4'h0});
        for (int i = 0; i < 3; i++)
            rd_chk(IDX_PTR0 + 7'(i), p_val[i], "pointer");
        rtctk_host_inst.reg_wr(IDX_CRA, {1'b0, DV_BANK1, 4'h0});
        rtctk_host_inst.reg_wr(IDX_DALM, 8'hc0);
        rtctk_host_inst.reg_wr(IDX_MALM, 8'hc0);
        rd_chk(IDX_MALM, 8'hc0, "month alarm");
        $display("test reset and banks done");
        // bit 7 written high must read back low while the chain is held
        rtctk_host_inst.reg_wr(IDX_CRA, 8'hf0);
        rd_chk(IDX_CRA, 8'h70, "ctrl a held");
        for (int i = 0; i < 10; i++)
            rtctk_host_inst.reg_wr(s_idx[i], s_val[i]);
        rtctk_host_inst.reg_wr(IDX_CRB, 8'h32);
        rtctk_host_inst.reg_wr(IDX_CRA, 8'h2f);
        tick(8190);
        rd_chk(IDX_CRC, 8'h00, "early periodic");
        tick(4);
        rd_chk(IDX_CRC, 8'h40, "first periodic");
        chk("irq masked", 8'h01, {7'h00, irq_n});
        tick(8189);
        rd_chk(IDX_CRA, 8'h2f, "no pending");
        tick(1);
        rd_chk(IDX_CRA, 8'haf, "pending");
        tick(7);
        rd_chk(IDX_SEC, 8'h59, "not yet");
        chk("irq idle", 8'h01, {7'h00, irq_n});
        tick(1);
        for (int i = 0; i < 8 && irq_n !== 1'b0; i++)
            @(negedge clock);
        chk("irq raised", 8'h00, {7'h00, irq_n});
        rd_chk(IDX_CRC, 8'hb0, "update flags");
        chk("irq cleared", 8'h01, {7'h00, irq_n});
        for (int i = 0; i < 10; i++)
            rd_chk(s_idx[i], t_val[i], "time");
        $display("test update and alarm done");
        rtctk_host_inst.reg_wr(IDX_CRB, 8'hb2);
        // bring the divider into the pending window while set is high
        tick(32760);
        rd_chk(IDX_CRA, 8'h2f, "set hides pending");
        tick(8);
        rd_chk(IDX_SEC, 8'h00, "frozen");
        rd_chk(IDX_CRC, 8'hd0, "no alarm");
        rtctk_host_inst.reg_wr(IDX_SEC, 8'h30);
        rtctk_host_inst.reg_wr(IDX_CRB, 8'h32);
        rd_chk(IDX_SEC, 8'h30, "loaded");
        rtctk_host_inst.reg_wr(IDX_CRB, 8'h36);
        rd_chk(IDX_SEC, 8'h1e, "binary");
        rtctk_host_inst.reg_wr(IDX_CRB, 8'h30);
        rd_chk(IDX_SEC + 7'h04, 8'h12, "12 hour");
        @(negedge clock);
        io_base = 16'h0270;
        rd_chk(IDX_CRB, 8'h30, "moved base");
        $display("test formats done");
        rtctk_host_inst.reg_wr(IDX_CRB, 8'h33);
        for (int i = 0; i < 5; i++)
            rtctk_host_inst.reg_wr(s_idx[2 * i], d_val[i]);
        rtctk_host_inst.reg_wr(IDX_CRA, 8'h60);
        rtctk_host_inst.reg_wr(IDX_CRA, 8'h2f);
        tick(16392);
        rd_chk(IDX_SEC + 7'h04, 8'h03, "spring hour");
        rd_chk(IDX_SEC + 7'h02, 8'h00, "spring min");
        $display("test summer time done");
        close_out();
    end
endmodule
bind rtctk_core rtctk_chk rtctk_chk_inst (.CLOCK_I(CLOCK_I),
    .RSTN_I(RSTN_I), .OSC_TICK_I(OSC_TICK_I), .IO_BASE_I(IO_BASE_I),
    .IO_ADDR_I(IO_ADDR_I), .IO_RD_I(IO_RD_I), .IO_WR_I(IO_WR_I),
    .IO_WDATA_I(IO_WDATA_I), .IO_RDATA_O(IO_RDATA_O), .IRQ_N_O(IRQ_N_O));
`default_nettype wire
